// File: hdl/gpio_pad_ctrl_and_irq_mask.sv
// Port 5/6/8 pad control, interrupt masking and port-6 change wake-up.
// Assumes synchronous pin inputs and a core that executes the vector or
// next-instruction request given on resume_vector / resume_next.
// Operation
// - Pull-down bits 7..4 port6, bit0 port5
// - Pull-down bits 3..1 always zero
// - Open-drain bits 5..0 for port 6
// - Pull-high bits 5..0, zero enables pullup
// - Second mask bit 7 gates comparator2
// - Second mask bit 5 gates timer3
// - First mask bit 6 gates conversion done
// - First mask bits 2..0 gate ext/change/timer
// - Interrupt needs mask bit and global enable
// - Control registers read back written bits; unused bits read zero
// - Ports 5,6,8 per-pin tri-state direction
// - Port-6 change with enables vectors to 006H
// - Wake-up: vector if change mask and global on, else next
// - Change mask clear: resume next instruction
// - Direction 1 input, 0 output
// - Ext select routes port6 pin0 as interrupt
module gpio_pad_ctrl_and_irq_mask #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output logic      [7:0]       reg_rdata,
  input  wire logic [WIDTH-1:0] port5_in,
  output logic      [WIDTH-1:0] port5_out,
  output logic      [WIDTH-1:0] port5_oe_n,
  input  wire logic [WIDTH-1:0] port6_in,
  output logic      [WIDTH-1:0] port6_out,
  output logic      [WIDTH-1:0] port6_oe_n,
  input  wire logic [WIDTH-1:0] port8_in,
  output logic      [WIDTH-1:0] port8_out,
  output logic      [WIDTH-1:0] port8_oe_n,
  output logic      [WIDTH-1:0] port6_pullup_en,
  output logic      [WIDTH-1:0] port6_pulldown_en,
  output logic                  port5_pulldown_en,
  input  wire logic             freerun_timer_event,
  input  wire logic             timer3_event,
  input  wire logic             conv_done_event,
  input  wire logic             comparator2_event,
  input  wire logic             global_irq_on_instr,
  input  wire logic             global_irq_off_instr,
  input  wire logic             sleep_instr,
  input  wire logic             irq_ack,
  output logic                  irq_request,
  output logic                  resume_vector,
  output logic                  resume_next,
  output logic      [7:0]       vector_addr,
  output logic                  asleep
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {RUNNING, SLEEPING, RESUMING} power_t;

  typedef struct packed {
    logic [WIDTH-1:0] port5_data;
    logic [WIDTH-1:0] port6_data;
    logic [WIDTH-1:0] port8_data;
    logic [WIDTH-1:0] dir_ctrl_port5;
    logic [WIDTH-1:0] dir_ctrl_port6;
    logic [WIDTH-1:0] dir_ctrl_port8;
    logic [7:0]       pulldown_ctrl;
    logic [7:0]       opendrain_ctrl;
    logic [7:0]       pullhigh_ctrl;
    logic [7:0]       irq_mask_second;
    logic [7:0]       irq_mask_first;
    logic [5:0]       flags;
    logic [WIDTH-1:0] port6_snapshot;
    logic             global_irq;
    logic             ext_irq_pin_select;
    logic             wake_enable;
    logic             ext_pin_prev;
    power_t           power;
    logic             resume_vector;
    logic             resume_next;
    logic [7:0]       rdata;
  } state_t;

  state_t cur;
  state_t next_s;

  logic [WIDTH-1:0] port6_view;
  logic [5:0]       event_in;
  logic [5:0]       enables;
  logic             change_seen;
  logic             ext_fall;
  logic [WIDTH-1:0] port5_view;
  logic [WIDTH-1:0] port8_view;
  logic [5:0]       pending;
  logic [7:0]       read_word;

  // ****************************************
  // Pad drive
  // ****************************************
  always_comb
  begin
    port5_out  = cur.port5_data;
    port8_out  = cur.port8_data;
    port5_oe_n = cur.dir_ctrl_port5;
    port8_oe_n = cur.dir_ctrl_port8;
    for (int i = 0; i < WIDTH; i++)
    begin
      port6_out[i] = cur.port6_data[i];
      // Open-drain pins drive only low; a high releases the pad
      if (i < 6 && cur.opendrain_ctrl[i])
        port6_oe_n[i] = cur.dir_ctrl_port6[i] | cur.port6_data[i];
      else
        port6_oe_n[i] = cur.dir_ctrl_port6[i];
      if (i < 6)
        port6_pullup_en[i] = ~cur.pullhigh_ctrl[i];
      else
        port6_pullup_en[i] = 1'b0;
      // Only pins 0..3 have a pull-down; the modulo keeps the index in range
      if (i < 4)
        port6_pulldown_en[i] = ~cur.pulldown_ctrl[gpio_pad_pkg::PD_P6_LSB + (i % 4)];
      else
        port6_pulldown_en[i] = 1'b0;
    end
    port5_pulldown_en = ~cur.pulldown_ctrl[gpio_pad_pkg::PD_P5_0];
  end

  // ****************************************
  // Pin views and change detect
  // ****************************************
  // Reads see pin level on inputs, latch on outputs
  assign port6_view = (cur.dir_ctrl_port6 & port6_in) | (~cur.dir_ctrl_port6 & cur.port6_data);
  assign port5_view = (cur.dir_ctrl_port5 & port5_in) | (~cur.dir_ctrl_port5 & cur.port5_data);
  assign port8_view = (cur.dir_ctrl_port8 & port8_in) | (~cur.dir_ctrl_port8 & cur.port8_data);
  assign change_seen = |((port6_view ^ cur.port6_snapshot) & cur.dir_ctrl_port6);
  // External pin is active low; path masked unless selected
  assign ext_fall = cur.ext_irq_pin_select & cur.ext_pin_prev & ~port6_in[0];

  // ****************************************
  // Events and their enables
  // ****************************************
  always_comb
  begin
    event_in = '0;
    event_in[gpio_pad_pkg::FL_FREERUN] = freerun_timer_event;
    event_in[gpio_pad_pkg::FL_CHANGE]  = change_seen;
    event_in[gpio_pad_pkg::FL_EXT]     = ext_fall;
    event_in[gpio_pad_pkg::FL_TIMER3]  = timer3_event;
    event_in[gpio_pad_pkg::FL_CONV]    = conv_done_event;
    event_in[gpio_pad_pkg::FL_CMP2]    = comparator2_event;
    enables = '0;
    enables[gpio_pad_pkg::FL_FREERUN] = cur.irq_mask_first[gpio_pad_pkg::M1_FREERUN];
    enables[gpio_pad_pkg::FL_CHANGE]  = cur.irq_mask_first[gpio_pad_pkg::M1_CHANGE];
    enables[gpio_pad_pkg::FL_EXT]     = cur.irq_mask_first[gpio_pad_pkg::M1_EXT];
    enables[gpio_pad_pkg::FL_TIMER3]  = cur.irq_mask_second[gpio_pad_pkg::M2_TIMER3];
    enables[gpio_pad_pkg::FL_CONV]    = cur.irq_mask_first[gpio_pad_pkg::M1_CONV];
    enables[gpio_pad_pkg::FL_CMP2]    = cur.irq_mask_second[gpio_pad_pkg::M2_CMP2];
  end

  assign pending = cur.flags & enables;

  // ****************************************
  // Read data
  // ****************************************
  // Unmapped words read zero
  always_comb
  begin
    read_word = 8'h00;
    if (reg_addr == gpio_pad_pkg::ADDR_PORT5_DATA)
      read_word = port5_view;
    else if (reg_addr == gpio_pad_pkg::ADDR_PORT6_DATA)
      read_word = port6_view;
    else if (reg_addr == gpio_pad_pkg::ADDR_PORT8_DATA)
      read_word = port8_view;
    else if (reg_addr == gpio_pad_pkg::ADDR_DIR_PORT5)
      read_word = cur.dir_ctrl_port5;
    else if (reg_addr == gpio_pad_pkg::ADDR_DIR_PORT6)
      read_word = cur.dir_ctrl_port6;
    else if (reg_addr == gpio_pad_pkg::ADDR_DIR_PORT8)
      read_word = cur.dir_ctrl_port8;
    else if (reg_addr == gpio_pad_pkg::ADDR_PULLDOWN)
      read_word = cur.pulldown_ctrl;
    else if (reg_addr == gpio_pad_pkg::ADDR_OPENDRAIN)
      read_word = cur.opendrain_ctrl;
    else if (reg_addr == gpio_pad_pkg::ADDR_PULLHIGH)
      read_word = cur.pullhigh_ctrl;
    else if (reg_addr == gpio_pad_pkg::ADDR_IRQ_MASK_2ND)
      read_word = cur.irq_mask_second;
    else if (reg_addr == gpio_pad_pkg::ADDR_IRQ_MASK_1ST)
      read_word = cur.irq_mask_first;
    else if (reg_addr == gpio_pad_pkg::ADDR_IRQ_FLAGS)
      read_word = {2'b00, cur.flags};
    else if (reg_addr == gpio_pad_pkg::ADDR_CORE_CTRL)
      read_word = {4'h0, cur.power == SLEEPING, cur.wake_enable,
                   cur.ext_irq_pin_select, cur.global_irq};
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_s = cur;
    next_s.resume_vector = 1'b0;
    next_s.resume_next   = 1'b0;
    next_s.rdata         = 8'h00;
    next_s.ext_pin_prev  = port6_in[0];

    // Set wins over clear: clear first, then OR in events
    if (irq_ack)
      next_s.flags = cur.flags & ~pending;
    if (reg_write && reg_addr == gpio_pad_pkg::ADDR_IRQ_FLAGS)
      next_s.flags = next_s.flags & ~reg_wdata[5:0];

    // Enable wins if both instructions land together
    if (global_irq_on_instr)
      next_s.global_irq = 1'b1;
    else if (global_irq_off_instr)
      next_s.global_irq = 1'b0;

    // Only existing bits are stored, so unused bits read zero
    if (reg_write)
    begin
      if (reg_addr == gpio_pad_pkg::ADDR_PORT5_DATA)
        next_s.port5_data = reg_wdata;
      else if (reg_addr == gpio_pad_pkg::ADDR_PORT6_DATA)
        next_s.port6_data = reg_wdata;
      else if (reg_addr == gpio_pad_pkg::ADDR_PORT8_DATA)
        next_s.port8_data = reg_wdata;
      else if (reg_addr == gpio_pad_pkg::ADDR_DIR_PORT5)
        next_s.dir_ctrl_port5 = reg_wdata;
      else if (reg_addr == gpio_pad_pkg::ADDR_DIR_PORT6)
        next_s.dir_ctrl_port6 = reg_wdata;
      else if (reg_addr == gpio_pad_pkg::ADDR_DIR_PORT8)
        next_s.dir_ctrl_port8 = reg_wdata;
      else if (reg_addr == gpio_pad_pkg::ADDR_PULLDOWN)
        next_s.pulldown_ctrl = reg_wdata & gpio_pad_pkg::PULLDOWN_MASK;
      else if (reg_addr == gpio_pad_pkg::ADDR_OPENDRAIN)
        next_s.opendrain_ctrl = reg_wdata & gpio_pad_pkg::OPENDRAIN_MASK;
      else if (reg_addr == gpio_pad_pkg::ADDR_PULLHIGH)
        next_s.pullhigh_ctrl = reg_wdata & gpio_pad_pkg::PULLHIGH_MASK;
      else if (reg_addr == gpio_pad_pkg::ADDR_IRQ_MASK_2ND)
        next_s.irq_mask_second = reg_wdata & gpio_pad_pkg::IRQ_MASK_2ND_MASK;
      else if (reg_addr == gpio_pad_pkg::ADDR_IRQ_MASK_1ST)
        next_s.irq_mask_first = reg_wdata & gpio_pad_pkg::IRQ_MASK_1ST_MASK;
      else if (reg_addr == gpio_pad_pkg::ADDR_CORE_CTRL)
      begin
        next_s.global_irq         = reg_wdata[gpio_pad_pkg::CC_GLOBAL_IRQ];
        next_s.ext_irq_pin_select = reg_wdata[gpio_pad_pkg::CC_EXT_SELECT];
        next_s.wake_enable        = reg_wdata[gpio_pad_pkg::CC_WAKE_ENABLE];
      end
    end

    if (reg_read)
    begin
      next_s.rdata = read_word;
      // Change detect compares against what software last read
      if (reg_addr == gpio_pad_pkg::ADDR_PORT6_DATA)
        next_s.port6_snapshot = port6_view;
    end

    // Events land last so they win over any clear this cycle
    next_s.flags = next_s.flags | event_in;

    case (cur.power)
      RUNNING:
      begin
        if (sleep_instr)
          next_s.power = SLEEPING;
      end
      SLEEPING:
      begin
        // Only the change path wakes; its mask and the global enable pick vector or next
        if (cur.wake_enable && change_seen)
        begin
          next_s.power = RESUMING;
        end
      end
      RESUMING:
      begin
        next_s.power = RUNNING;
        // A clear change mask always resumes at the next instruction
        if (cur.irq_mask_first[gpio_pad_pkg::M1_CHANGE] && cur.global_irq)
          next_s.resume_vector = 1'b1;
        else
          next_s.resume_next = 1'b1;
      end
      default:
        next_s.power = RUNNING;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      // Pins start as inputs so nothing drives the pads in reset
      cur.flags              <= '0;
      cur.port6_snapshot     <= '0;
      cur.global_irq         <= 1'b0;
      cur.ext_irq_pin_select <= 1'b0;
      cur.wake_enable        <= 1'b0;
      cur.resume_vector      <= 1'b0;
      cur.resume_next        <= 1'b0;
      cur.rdata              <= 8'h00;
      cur.port5_data         <= gpio_pad_pkg::DATA_RST;
      cur.port6_data         <= gpio_pad_pkg::DATA_RST;
      cur.port8_data         <= gpio_pad_pkg::DATA_RST;
      cur.dir_ctrl_port5     <= gpio_pad_pkg::DIR_RST;
      cur.dir_ctrl_port6     <= gpio_pad_pkg::DIR_RST;
      cur.dir_ctrl_port8     <= gpio_pad_pkg::DIR_RST;
      cur.pulldown_ctrl      <= gpio_pad_pkg::PULLDOWN_RST;
      cur.opendrain_ctrl     <= gpio_pad_pkg::OPENDRAIN_RST;
      cur.pullhigh_ctrl      <= gpio_pad_pkg::PULLHIGH_RST;
      cur.irq_mask_second    <= gpio_pad_pkg::IRQ_MASK_RST;
      cur.irq_mask_first     <= gpio_pad_pkg::IRQ_MASK_RST;
      cur.ext_pin_prev       <= 1'b1;
      cur.power              <= RUNNING;
    end
    else
      cur <= next_s;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata     = cur.rdata;
  assign irq_request   = cur.global_irq && (cur.power == RUNNING)
                         && |pending;
  assign resume_vector = cur.resume_vector;
  assign resume_next   = cur.resume_next;
  // Vector is fixed; the core performs the jump
  assign vector_addr   = gpio_pad_pkg::CHANGE_VECTOR;
  assign asleep        = (cur.power == SLEEPING);

endmodule

// File: shared/gpio_pad_pkg.sv
// Package for the pad control and interrupt mask block.
// Assumes a single core clock domain and a plain register port.
package gpio_pad_pkg;

  // ****************************************
  // Register map (word indices on reg port)
  // ****************************************
  localparam logic [3:0] ADDR_PORT5_DATA   = 4'h0;
  localparam logic [3:0] ADDR_PORT6_DATA   = 4'h1;
  localparam logic [3:0] ADDR_PORT8_DATA   = 4'h2;
  localparam logic [3:0] ADDR_DIR_PORT5    = 4'h3;
  localparam logic [3:0] ADDR_DIR_PORT6    = 4'h4;
  localparam logic [3:0] ADDR_DIR_PORT8    = 4'h5;
  localparam logic [3:0] ADDR_PULLDOWN     = 4'h6;
  localparam logic [3:0] ADDR_OPENDRAIN    = 4'h7;
  localparam logic [3:0] ADDR_PULLHIGH     = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK_2ND = 4'h9;
  localparam logic [3:0] ADDR_IRQ_MASK_1ST = 4'hA;
  localparam logic [3:0] ADDR_IRQ_FLAGS    = 4'hB;
  localparam logic [3:0] ADDR_CORE_CTRL    = 4'hC;

  // ****************************************
  // Writable bit masks (unused bits read 0)
  // ****************************************
  localparam logic [7:0] PULLDOWN_MASK     = 8'hF1;
  localparam logic [7:0] OPENDRAIN_MASK    = 8'h3F;
  localparam logic [7:0] PULLHIGH_MASK     = 8'h3F;
  localparam logic [7:0] IRQ_MASK_2ND_MASK = 8'hA0;
  localparam logic [7:0] IRQ_MASK_1ST_MASK = 8'h47;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PULLDOWN_RST      = 8'hF1;
  localparam logic [7:0] OPENDRAIN_RST     = 8'h00;
  localparam logic [7:0] PULLHIGH_RST      = 8'h3F;
  localparam logic [7:0] IRQ_MASK_RST      = 8'h00;
  localparam logic [7:0] DIR_RST           = 8'hFF;
  localparam logic [7:0] DATA_RST          = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PD_P6_LSB       = 4;
  localparam int PD_P5_0         = 0;
  localparam int M2_CMP2         = 7;
  localparam int M2_TIMER3       = 5;
  localparam int M1_CONV         = 6;
  localparam int M1_EXT          = 2;
  localparam int M1_CHANGE       = 1;
  localparam int M1_FREERUN      = 0;
  // Flag register bits
  localparam int FL_FREERUN      = 0;
  localparam int FL_CHANGE       = 1;
  localparam int FL_EXT          = 2;
  localparam int FL_TIMER3       = 3;
  localparam int FL_CONV         = 4;
  localparam int FL_CMP2         = 5;
  localparam int FL_COUNT        = 6;
  // Core control register bits
  localparam int CC_GLOBAL_IRQ   = 0;
  localparam int CC_EXT_SELECT   = 1;
  localparam int CC_WAKE_ENABLE  = 2;
  localparam int CC_ASLEEP       = 3;

  localparam logic [7:0] CHANGE_VECTOR = 8'h06;

endpackage

// File: sim/pin_board.sv
// Board model for the port 6 pins.
// Assumes pad controls from the block; the bench picks pins it drives.
module pin_board (
  input  wire logic       clk_sys,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_dn,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drift = 8'h55;
  // Floating pin wanders, so a stale level never passes for a real one
  always @(posedge clk_sys) drift <= ~drift;
  always_comb
    for (int i = 0; i < 8; i++)
      pins[i] = ext_en[i] ? ext_val[i] : !pad_oe_n[i] ? pad_out[i] :
        pull_up[i] ? 1'b1 : pull_dn[i] ? 1'b0 : drift[i];
endmodule

// File: sim/gpio_pad_ctrl_and_irq_mask_sva.sv
// Port-level checker for the pad control block.
// Assumes one clock domain; bound to the block below.
module gpio_pad_sva #(
  parameter int WIDTH = 8
) (
  input wire logic             clk_sys,
  input wire logic             nrst,
  input wire logic [3:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_write,
  input wire logic             reg_read,
  input wire logic [7:0]       reg_rdata,
  input wire logic [WIDTH-1:0] port5_oe_n,
  input wire logic [WIDTH-1:0] port6_pullup_en,
  input wire logic [WIDTH-1:0] port6_pulldown_en,
  input wire logic             port5_pulldown_en,
  input wire logic             irq_request,
  input wire logic             resume_vector,
  input wire logic             resume_next,
  input wire logic [7:0]       vector_addr,
  input wire logic             asleep
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_rd_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_vec; vector_addr == 8'h06; endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_dir5; reg_write && reg_addr == 4'h3 |=> port5_oe_n == $past(reg_wdata); endproperty
  a_dir5: assert property (p_dir5) else $error("port5 enable wrong");
  property p_pd5; reg_write && reg_addr == 4'h6 |=> port5_pulldown_en == !$past(reg_wdata[0]);
  endproperty
  a_pd5: assert property (p_pd5) else $error("port5 pulldown wrong");
  property p_pd6;
    reg_write && reg_addr == 4'h6 |=> port6_pulldown_en == {4'h0, ~$past(reg_wdata[7:4])};
  endproperty
  a_pd6: assert property (p_pd6) else $error("port6 pulldown wrong");
  property p_pu;
    reg_write && reg_addr == 4'h8 |=> port6_pullup_en == {2'b00, ~$past(reg_wdata[5:0])};
  endproperty
  a_pu: assert property (p_pu) else $error("port6 pullup wrong");
  property p_m2; reg_read && reg_addr == 4'h9 |=> (reg_rdata & 8'h5F) == 8'h00; endproperty
  a_m2: assert property (p_m2) else $error("second mask unused bits set");
  property p_m1; reg_read && reg_addr == 4'hA |=> (reg_rdata & 8'hB8) == 8'h00; endproperty
  a_m1: assert property (p_m1) else $error("first mask unused bits set");
  property p_sleep; asleep |-> !irq_request; endproperty
  a_sleep: assert property (p_sleep) else $error("request while asleep");
  property p_wake; $fell(asleep) |-> ##[0:1] (resume_vector || resume_next); endproperty
  a_wake: assert property (p_wake) else $error("no resume after wake");
  property p_pulse;
    resume_vector |-> !resume_next ##1 !resume_vector && !resume_next;
  endproperty
  a_pulse: assert property (p_pulse) else $error("resume pulse wrong");
  c_vec: cover property (resume_vector);
  c_next: cover property (resume_next);
  c_irq: cover property (irq_request);
endmodule
bind gpio_pad_ctrl_and_irq_mask gpio_pad_sva #(.WIDTH(WIDTH)) sva_i (
  .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .port5_oe_n, .port6_pullup_en, .port6_pulldown_en, .port5_pulldown_en,
  .irq_request, .resume_vector, .resume_next, .vector_addr, .asleep
);

// File: sim/gpio_pad_ctrl_and_irq_mask_tb.sv
// Self-checking bench for the pad control and interrupt mask block.
// Assumes the board model on port 6 and a 20 MHz core clock.
module gpio_pad_ctrl_and_irq_mask_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 0, nrst = 0, reg_write = 0, reg_read = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, st = 8'h00, drv = 8'h2A, p5_in = 8'h00, p8_in = 8'h00;
  logic [7:0] reg_rdata, p5_out, p5_oe_n, p6_in, p6_out, p6_oe_n, p8_out, p8_oe_n;
  logic [7:0] pu6, pd6, vector_addr;
  logic [7:0] ext_en = 8'hFF;
  logic       pd5, irq_request, resume_vector, resume_next, asleep;
  int         mismatches = 0, cmp_count = 0;
  always #25 clk_sys = ~clk_sys;
  gpio_pad_ctrl_and_irq_mask dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port5_in(p5_in), .port5_out(p5_out), .port5_oe_n(p5_oe_n),
    .port6_in(p6_in), .port6_out(p6_out), .port6_oe_n(p6_oe_n),
    .port8_in(p8_in), .port8_out(p8_out), .port8_oe_n(p8_oe_n),
    .port6_pullup_en(pu6), .port6_pulldown_en(pd6), .port5_pulldown_en(pd5),
    .freerun_timer_event(st[0]), .timer3_event(st[1]), .conv_done_event(st[2]),
    .comparator2_event(st[3]), .irq_ack(st[4]), .global_irq_on_instr(st[5]),
    .global_irq_off_instr(st[6]), .sleep_instr(st[7]), .irq_request(irq_request),
    .resume_vector(resume_vector), .resume_next(resume_next),
    .vector_addr(vector_addr), .asleep(asleep)
  );
  pin_board board (
    .clk_sys(clk_sys), .pad_out(p6_out), .pad_oe_n(p6_oe_n), .pull_up(pu6),
    .pull_dn(pd6), .ext_val(drv), .ext_en(ext_en), .pins(p6_in)
  );
  // ********
  // Bus and compare helpers
  // ********
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    st[k] <= 1'b1;
    @(posedge clk_sys);
    st[k] <= 1'b0;
    @(negedge clk_sys);
  endtask
  // Latch agrees with pins, so either read-back reading holds
  task automatic snap;
    wr(4'h1, drv);
    rd(4'h1, drv);
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    logic [7:0] rv[5] = '{8'hF1, 8'h00, 8'h3F, 8'h00, 8'h00};
    logic [7:0] mk[5] = '{8'hF1, 8'h3F, 8'h3F, 8'hA0, 8'h47};
    for (int i = 0; i < 5; i++)
    begin
      rd(4'(i + 6), rv[i]);
      wr(4'(i + 6), 8'hFF);
      rd(4'(i + 6), mk[i]);
      wr(4'(i + 6), 8'h00);
      rd(4'(i + 6), 8'h00);
    end
    for (int i = 3; i < 6; i++)
    begin
      rd(4'(i), 8'hFF);
      wr(4'(i), 8'h5A);
      rd(4'(i), 8'h5A);
      wr(4'(i), 8'hFF);
    end
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
  endtask
  task automatic t_pads;
    wr(4'h4, 8'h00);
    wr(4'h1, 8'h2A);
    wr(4'h7, 8'h0F);
    wr(4'h8, 8'h15);
    wr(4'h6, 8'h50);
    wr(4'h3, 8'h0F);
    wr(4'h0, 8'hC3);
    @(negedge clk_sys);
    chk("port6_oe_n", 8'h0A, p6_oe_n);
    chk("port6_out", 8'h2A, p6_out);
    chk("port6_pullup_en", 8'h2A, pu6);
    chk("port6_pulldown_en", 8'h0A, pd6);
    chk("port5_pulldown_en", 8'h01, 8'(pd5));
    chk("port5_oe_n", 8'h0F, p5_oe_n);
    chk("port5_out", 8'hC3, p5_out);
    wr(4'h5, 8'hF0);
    wr(4'h2, 8'h96);
    @(negedge clk_sys);
    chk("port8_oe_n", 8'hF0, p8_oe_n);
    chk("port8_out", 8'h96, p8_out);
    rd(4'h2, 8'h06);
    rd(4'h0, 8'hC0);
    wr(4'h5, 8'hFF);
    wr(4'h4, 8'hFF);
    wr(4'h7, 8'h00);
    // Release pins 0..5 so only the pulls set their level
    wr(4'h8, 8'h0F);
    wr(4'h6, 8'h01);
    @(posedge clk_sys);
    ext_en <= 8'hC0;
    rd(4'h1, 8'h30);
    @(posedge clk_sys);
    ext_en <= 8'hFF;
  endtask
  task automatic t_ext(input logic [7:0] ctrl, input logic [7:0] exp);
    wr(4'hC, ctrl);
    wr(4'hA, 8'h04);
    @(posedge clk_sys);
    drv[0] <= 1'b1;
    wr(4'hB, 8'hFF);
    @(negedge clk_sys);
    chk("irq_request", 8'h00, 8'(irq_request));
    @(posedge clk_sys);
    drv[0] <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("irq_request", exp, 8'(irq_request));
    pulse(4);
    wr(4'hA, 8'h00);
  endtask
  task automatic t_irq;
    logic [3:0] ma[4] = '{4'hA, 4'h9, 4'hA, 4'h9};
    logic [7:0] mb[4] = '{8'h01, 8'h20, 8'h40, 8'h80};
    for (int i = 0; i < 4; i++)
    begin
      pulse(i);
      pulse(5);
      chk("irq_request", 8'h00, 8'(irq_request));
      wr(ma[i], mb[i]);
      @(negedge clk_sys);
      chk("irq_request", 8'h01, 8'(irq_request));
      pulse(6);
      chk("irq_request", 8'h00, 8'(irq_request));
      pulse(5);
      chk("irq_request", 8'h01, 8'(irq_request));
      pulse(4);
      chk("irq_request", 8'h00, 8'(irq_request));
      wr(ma[i], 8'h00);
    end
  endtask
  task automatic t_change;
    snap();
    wr(4'hB, 8'hFF);
    wr(4'hA, 8'h02);
    @(negedge clk_sys);
    chk("irq_request", 8'h00, 8'(irq_request));
    @(posedge clk_sys);
    drv <= drv ^ 8'h08;
    repeat (2) @(negedge clk_sys);
    chk("irq_request", 8'h01, 8'(irq_request));
    chk("vector_addr", 8'h06, vector_addr);
    rd(4'hB, 8'h02);
    snap();
    pulse(4);
    repeat (2) @(negedge clk_sys);
    chk("irq_request", 8'h00, 8'(irq_request));
  endtask
  task automatic t_sleep(input logic [7:0] mask, input logic [7:0] ctrl, input logic vec);
    int n;
    snap();
    wr(4'hB, 8'hFF);
    wr(4'hA, mask);
    wr(4'hC, ctrl);
    pulse(7);
    chk("asleep", 8'h01, 8'(asleep));
    @(posedge clk_sys);
    drv <= drv ^ 8'h10;
    for (n = 0; n < 10 && resume_vector !== 1'b1 && resume_next !== 1'b1; n++)
      @(negedge clk_sys);
    chk("resume_vector", 8'(vec), 8'(resume_vector));
    chk("resume_next", 8'(!vec), 8'(resume_next));
    pulse(4);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_pads();
    t_irq();
    t_change();
    t_ext(8'h03, 8'h01);
    t_ext(8'h01, 8'h00);
    t_sleep(8'h02, 8'h05, 1'b1);
    t_sleep(8'h02, 8'h04, 1'b0);
    t_sleep(8'h00, 8'h05, 1'b0);
    wrap_up();
  end
  // Run needs well under a thousand cycles
  initial
  begin
    #2000000;
    mismatches++;
    wrap_up();
  end
endmodule
